//--- atig_core.v
// Transfer group execution unit with APB control and status
//
// The register offsets and the APB slave port were chosen for this implementation.
`include "atig_defs.vh"

// Functional notes
// - Prescaler high nibble to B, low to A
// - Opcode 0001010001 copies pointer extension to A[2:0]
// - Pointer extension transfer clears A bit 3
// - Copy first interrupt control into A, unchanged
// - Opcode 1001010100 copies second interrupt control
// - Copy first wakeup control register into A
module atig_core #(
  parameter CNT_W = `ATIG_CNT_W           // Execution counter width
) (
  input  wire                CORE_CLK_IN,          // Core clock, 200 MHz
  input  wire                SYS_RST_IN,           // Async reset, active high
  input  wire [`ATIG_IW-1:0] INSTR_IN,             // Fetched instruction
  input  wire                INSTR_VALID_IN,       // Instruction cycle strobe
  input  wire                CARRY_IN,             // Carry flag from the core
  input  wire [7:0]          PRESCALER_COUNT_IN,   // Prescaler count
  input  wire [2:0]          POINTER_EXT_REG_IN,   // Pointer extension register
  input  wire [3:0]          INT_CTRL_ONE_IN,      // First interrupt control
  input  wire [3:0]          INT_CTRL_TWO_IN,      // Second interrupt control
  input  wire [3:0]          WAKE_CTRL_ZERO_IN,    // First wakeup control
  input  wire                PSEL_IN,              // APB select
  input  wire                PENABLE_IN,           // APB enable
  input  wire                PWRITE_IN,            // APB direction
  input  wire [11:0]         PADDR_IN,             // APB byte address
  input  wire [31:0]         PWDATA_IN,            // APB write data
  output wire [31:0]         PRDATA_OUT,           // APB read data
  output wire                PREADY_OUT,           // APB ready
  output wire                PSLVERR_OUT,          // APB error
  output wire [3:0]          ACC_OUT,              // Accumulator A
  output wire [3:0]          REG_B_OUT,            // Auxiliary register B
  output wire                CARRY_OUT,            // Carry flag after the cycle
  output wire                SKIP_OUT,             // Skip request for next word
  output wire                DONE_OUT              // Transfer executed pulse
);

  wire [2:0]       sel;          // Decoded source select
  reg  [3:0]       acc_q;        // Accumulator
  reg  [3:0]       acc_d;        // Next accumulator
  reg  [3:0]       b_q;          // Register B
  reg  [3:0]       b_d;          // Next register B
  reg              carry_q;      // Carry passed through
  reg              skip_q;       // Skip request
  reg              done_q;       // Executed pulse
  reg  [2:0]       last_q;       // Last executed source
  reg  [CNT_W-1:0] cnt_q;        // Executed transfer count
  reg              en_q;         // Decode enable
  reg  [31:0]      prdata_q;     // Read data holder
  reg              pready_q;     // Ready holder
  reg              pslverr_q;    // Error holder
  wire             exec;         // A transfer executes this cycle
  wire             mapped;       // Address hits a register

  // Opcode decoder
  atig_decode u_dec (
    .opcode_in (INSTR_IN),
    .sel_out   (sel)
  );

  // Execute qualifier
  // A transfer runs only in a valid instruction cycle
  // Decode enable must be set, else the word is ignored
  // Opcodes outside the group leave A, B, the count and the last source alone
  // Back to back transfers are allowed every cycle
  assign exec = INSTR_VALID_IN & en_q & (sel != `ATIG_SEL_NONE);

  // Source selection for the accumulator and B
  always @* begin
    acc_d = acc_q;
    b_d   = b_q;
    if (exec) begin
      case (sel)
        `ATIG_SEL_PSC: begin
          b_d   = PRESCALER_COUNT_IN[7:4];
          acc_d = PRESCALER_COUNT_IN[3:0];
        end
        `ATIG_SEL_PTR: begin
          acc_d = {1'b0, POINTER_EXT_REG_IN};
        end
        `ATIG_SEL_IC1: begin
          acc_d = INT_CTRL_ONE_IN;
        end
        `ATIG_SEL_IC2: begin
          acc_d = INT_CTRL_TWO_IN;
        end
        `ATIG_SEL_WK0: begin
          acc_d = WAKE_CTRL_ZERO_IN;
        end
        default: begin
          acc_d = acc_q;                            // Hold
        end
      endcase
    end
  end

  // Datapath registers, one instruction cycle per transfer
  // Sources are sampled at the execute edge itself
  // Results show one cycle after the word is presented
  // Done is a single-cycle pulse per executed transfer
  // Carry is passed through untouched, one stage late
  // Skip stays low: no transfer skips the next word
  // Counter wraps silently at its width
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      acc_q   <= 4'h0;
      b_q     <= 4'h0;
      carry_q <= 1'b0;
      skip_q  <= 1'b0;
      done_q  <= 1'b0;
      last_q  <= `ATIG_SEL_NONE;
      cnt_q   <= {CNT_W{1'b0}};
    end else begin
      acc_q   <= acc_d;
      b_q     <= b_d;
      carry_q <= CARRY_IN;
      skip_q  <= 1'b0;
      done_q  <= exec;
      if (exec) begin
        last_q <= sel;
        cnt_q  <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign mapped = (PADDR_IN == `ATIG_REG_CTRL) |
                  (PADDR_IN == `ATIG_REG_REGS) |
                  (PADDR_IN == `ATIG_REG_STAT);

  // Register map, one aligned word each
  // Control word: bit 0 is the decode enable
  // Control word resets to enabled
  // Register word: B in bits 7..4, A in bits 3..0
  // Register word is read only
  // Status word: transfer count above the last source
  // Status word is read only
  // Source codes: 0 none, 1 prescaler, 2 pointer
  // Source codes: 3 first int ctrl, 4 second int ctrl
  // Source code 5 is the first wakeup control
  // Unmapped addresses answer with an error
  // Unmapped reads return zero, writes are dropped

  // APB handshake
  // First access cycle is taken, ready follows a cycle on
  // Ready blocks a second take while it is high
  // Read data holds until the next access
  // Error and ready are single-cycle pulses

  // APB slave: one wait state, registered answer
  always @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      en_q      <= `ATIG_CTRL_RST;
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      if (PSEL_IN & PENABLE_IN & ~pready_q) begin
        // Access phase, first cycle: answer
        pready_q  <= 1'b1;
        pslverr_q <= ~mapped;
        prdata_q  <= 32'h0000_0000;
        if (PWRITE_IN) begin
          if (PADDR_IN == `ATIG_REG_CTRL) begin
            en_q <= PWDATA_IN[`ATIG_CTRL_EN];
          end
        end else begin
          case (PADDR_IN)
            `ATIG_REG_CTRL: prdata_q <= {31'h0000_0000, en_q};
            `ATIG_REG_REGS: prdata_q <= {24'h00_0000, b_q, acc_q};
            `ATIG_REG_STAT: prdata_q <= {{(32-CNT_W-3){1'b0}}, cnt_q, last_q};
            default:        prdata_q <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  assign PRDATA_OUT  = prdata_q;
  assign PREADY_OUT  = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign ACC_OUT     = acc_q;
  assign REG_B_OUT   = b_q;
  assign CARRY_OUT   = carry_q;
  assign SKIP_OUT    = skip_q;
  assign DONE_OUT    = done_q;

endmodule // atig_core

//--- atig_defs.vh
// Constants for the accumulator transfer instruction group
`ifndef ATIG_DEFS_VH
`define ATIG_DEFS_VH

// Instruction word width
`define ATIG_IW          10
// Opcodes of the transfer group
`define ATIG_OP_PSC      10'h275
`define ATIG_OP_PTR      10'h051
`define ATIG_OP_IC1      10'h253
`define ATIG_OP_IC2      10'h254
`define ATIG_OP_WK0      10'h256

// Decoded operation codes
`define ATIG_SEL_NONE    3'h0
`define ATIG_SEL_PSC     3'h1
`define ATIG_SEL_PTR     3'h2
`define ATIG_SEL_IC1     3'h3
`define ATIG_SEL_IC2     3'h4
`define ATIG_SEL_WK0     3'h5

// APB register byte offsets
`define ATIG_REG_CTRL    12'h000
`define ATIG_REG_REGS    12'h004
`define ATIG_REG_STAT    12'h008

// Control field positions and reset values
`define ATIG_CTRL_EN     0
`define ATIG_CTRL_RST    1'b1

// Execution counter width
`define ATIG_CNT_W       8

`endif

//--- atig_decode.v
// Opcode decoder for the accumulator transfer instruction group
`include "atig_defs.vh"

module atig_decode (
  input  wire [`ATIG_IW-1:0] opcode_in,  // Fetched instruction word
  output reg  [2:0]          sel_out     // Decoded transfer source
);

  // Map each opcode of the group onto its source select
  always @* begin
    case (opcode_in)
      `ATIG_OP_PSC: sel_out = `ATIG_SEL_PSC;   // Prescaler pair
      `ATIG_OP_PTR: sel_out = `ATIG_SEL_PTR;
      `ATIG_OP_IC1: sel_out = `ATIG_SEL_IC1;   // First interrupt control
      `ATIG_OP_IC2: sel_out = `ATIG_SEL_IC2;
      `ATIG_OP_WK0: sel_out = `ATIG_SEL_WK0;   // First wakeup control
      default:      sel_out = `ATIG_SEL_NONE;  // Not in this group
    endcase
  end

endmodule // atig_decode

//--- atig_core_assertions.sv
// Checker of the transfer group outputs against their sources
`include "atig_defs.vh"
module atig_chk (
  input logic       CORE_CLK_IN,
  input logic       SYS_RST_IN,
  input logic [9:0] INSTR_IN,
  input logic       CARRY_IN,
  input logic [7:0] PRESCALER_COUNT_IN,
  input logic [2:0] POINTER_EXT_REG_IN,
  input logic [3:0] INT_CTRL_ONE_IN,
  input logic [3:0] INT_CTRL_TWO_IN,
  input logic [3:0] WAKE_CTRL_ZERO_IN,
  input logic [3:0] ACC_OUT,
  input logic [3:0] REG_B_OUT,
  input logic       CARRY_OUT,
  input logic       SKIP_OUT,
  input logic       DONE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // Each done pulse ties A (and B for the prescaler pair) to the source seen one edge earlier
  property p_psc; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_PSC |->
    {REG_B_OUT, ACC_OUT} == $past(PRESCALER_COUNT_IN); endproperty
  a_psc: assert property (p_psc) else $error("prescaler pair");
  property p_ptr; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_PTR |->
    ACC_OUT == {1'h0, $past(POINTER_EXT_REG_IN)}; endproperty
  a_ptr: assert property (p_ptr) else $error("pointer ext");
  property p_ptr_b; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_PTR |->
    REG_B_OUT == $past(REG_B_OUT); endproperty
  a_ptr_b: assert property (p_ptr_b) else $error("pointer keeps b");
  property p_ic1; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_IC1 |->
    ACC_OUT == $past(INT_CTRL_ONE_IN); endproperty
  a_ic1: assert property (p_ic1) else $error("int ctrl one");
  property p_ic2; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_IC2 |->
    ACC_OUT == $past(INT_CTRL_TWO_IN); endproperty
  a_ic2: assert property (p_ic2) else $error("int ctrl two");
  property p_wk0; DONE_OUT && $past(INSTR_IN) == `ATIG_OP_WK0 |->
    ACC_OUT == $past(WAKE_CTRL_ZERO_IN); endproperty
  a_wk0: assert property (p_wk0) else $error("wake ctrl");
  // Carry passes through one stage, skip never raised
  property p_cy; !$past(SYS_RST_IN) |-> CARRY_OUT == $past(CARRY_IN); endproperty
  a_cy: assert property (p_cy) else $error("carry");
  property p_skip; !SKIP_OUT; endproperty
  a_skip: assert property (p_skip) else $error("skip");
endmodule // atig_chk

//--- tb_top.sv
// Self-checking bench of the transfer group
`include "atig_defs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic CORE_CLK_IN = 0, SYS_RST_IN = 1, INSTR_VALID_IN = 0, CARRY_IN = 0;
  logic PSEL_IN = 0, PENABLE_IN = 0, PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT;
  logic CARRY_OUT, SKIP_OUT, DONE_OUT;
  logic [9:0] INSTR_IN = 0;
  logic [7:0] PRESCALER_COUNT_IN = 0;
  logic [2:0] POINTER_EXT_REG_IN = 0;
  logic [3:0] INT_CTRL_ONE_IN = 0, INT_CTRL_TWO_IN = 0, WAKE_CTRL_ZERO_IN = 0;
  logic [3:0] ACC_OUT, REG_B_OUT, m_a = 0, m_b = 0;
  logic [11:0] PADDR_IN = 0;
  logic [31:0] PWDATA_IN = 0, PRDATA_OUT, rd;
  logic err, hit, rdy;
  logic [2:0] m_s = 0;
  int fail_count = 0, n_tests = 0, seed = 32'h3856, n_exec = 0;
  logic [9:0] ops [6] = '{`ATIG_OP_PSC, `ATIG_OP_PTR, `ATIG_OP_IC1, `ATIG_OP_IC2,
    `ATIG_OP_WK0, 10'h3ff};
  atig_core dut (.CORE_CLK_IN, .SYS_RST_IN, .INSTR_IN, .INSTR_VALID_IN, .CARRY_IN,
    .PRESCALER_COUNT_IN, .POINTER_EXT_REG_IN, .INT_CTRL_ONE_IN, .INT_CTRL_TWO_IN,
    .WAKE_CTRL_ZERO_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN, .PWDATA_IN,
    .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .ACC_OUT, .REG_B_OUT, .CARRY_OUT,
    .SKIP_OUT, .DONE_OUT);
  initial forever #2.5 CORE_CLK_IN = ~CORE_CLK_IN;
  // Verdict and end of run
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Source code expected for an opcode of the group
  function automatic logic [2:0] exp_sel(input logic [9:0] op);
    case (op)
      `ATIG_OP_PSC: return `ATIG_SEL_PSC;
      `ATIG_OP_PTR: return `ATIG_SEL_PTR;
      `ATIG_OP_IC1: return `ATIG_SEL_IC1;
      `ATIG_OP_IC2: return `ATIG_SEL_IC2;
      `ATIG_OP_WK0: return `ATIG_SEL_WK0;
      default: return `ATIG_SEL_NONE;
    endcase
  endfunction
  // One APB transfer; the request holds until ready is seen at a rising edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CORE_CLK_IN);
    PSEL_IN <= 1; PWRITE_IN <= w; PADDR_IN <= a; PWDATA_IN <= d;
    @(posedge CORE_CLK_IN);
    PENABLE_IN <= 1;
    rdy = 0;
    for (int k = 0; k < 50 && !rdy; k++) begin
      @(posedge CORE_CLK_IN);
      rdy = (PREADY_OUT === 1'h1);
    end
    if (!rdy) begin
      fail_count++;
      give_verdict;
    end else begin
      rd = PRDATA_OUT; err = PSLVERR_OUT;
      PSEL_IN <= 0; PENABLE_IN <= 0;
    end
  endtask
  // One instruction cycle with fresh random sources
  task run(input logic [9:0] op, input logic en);
    @(posedge CORE_CLK_IN);
    INSTR_IN <= op; INSTR_VALID_IN <= 1; CARRY_IN <= $random(seed);
    PRESCALER_COUNT_IN <= $random(seed); POINTER_EXT_REG_IN <= $random(seed);
    INT_CTRL_ONE_IN <= $random(seed); INT_CTRL_TWO_IN <= $random(seed);
    WAKE_CTRL_ZERO_IN <= $random(seed);
    @(posedge CORE_CLK_IN);
    INSTR_VALID_IN <= 0;
    #1 hit = en;
    if (en) case (op)
      `ATIG_OP_PSC: {m_b, m_a} = PRESCALER_COUNT_IN;
      `ATIG_OP_PTR: m_a = {1'h0, POINTER_EXT_REG_IN};
      `ATIG_OP_IC1: m_a = INT_CTRL_ONE_IN;
      `ATIG_OP_IC2: m_a = INT_CTRL_TWO_IN;
      `ATIG_OP_WK0: m_a = WAKE_CTRL_ZERO_IN;
      default: hit = 0;
    endcase
    if (hit) begin
      n_exec++;
      m_s = exp_sel(op);
    end
    chk("acc", ACC_OUT, m_a);
    chk("reg b", REG_B_OUT, m_b);
    chk("done", DONE_OUT, hit);
    chk("carry", CARRY_OUT, CARRY_IN);
    chk("skip", SKIP_OUT, 0);
  endtask
  initial begin
    repeat (20) @(posedge CORE_CLK_IN);
    SYS_RST_IN <= 0;
    for (int i = 0; i < 60; i++) run(ops[i < 6 ? i : $unsigned($random(seed)) % 6], 1);
    apb(1, `ATIG_REG_CTRL, 0);
    run(`ATIG_OP_PSC, 0);
    $display("disabled decode done");
    apb(1, `ATIG_REG_CTRL, 1);
    run(`ATIG_OP_PSC, 1);
    apb(0, `ATIG_REG_REGS, 0);
    chk("regs", rd[7:0], {m_b, m_a});
    apb(0, `ATIG_REG_CTRL, 0);
    chk("ctrl", rd, 1);
    apb(0, `ATIG_REG_STAT, 0);
    chk("stat", rd, {21'h0, n_exec[7:0], m_s});
    apb(0, 12'hffc, 0);
    chk("slverr", err, 1);
    chk("unmapped rd", rd, 0);
    $display("register access done");
    give_verdict;
  end
endmodule // tb_top
bind atig_core atig_chk chk (.CORE_CLK_IN, .SYS_RST_IN, .INSTR_IN, .CARRY_IN,
  .PRESCALER_COUNT_IN, .POINTER_EXT_REG_IN, .INT_CTRL_ONE_IN, .INT_CTRL_TWO_IN,
  .WAKE_CTRL_ZERO_IN, .ACC_OUT, .REG_B_OUT, .CARRY_OUT, .SKIP_OUT, .DONE_OUT);
